// >>> rtl/poac_pkg.sv
// Package of constants and carrier types for the PLL override and aux clock output block.
package poac_pkg;
   // ****************************************
   // Register offsets and field positions
   // ****************************************
   localparam logic [7:0] POAC_AUX_CTRL_ADDR = 8'h57;
   localparam logic [7:0] POAC_OVR_CTRL_ADDR = 8'h58;
   localparam logic [7:0] POAC_TRIM_ADDR = 8'h59;
   localparam logic [7:0] POAC_AUX_CTRL_RST = 8'h00;
   localparam logic [7:0] POAC_OVR_CTRL_RST = 8'h00;
   localparam logic [7:0] POAC_TRIM_RST = 8'h00;
   localparam int POAC_AUX_EN_BIT = 7;
   localparam int POAC_AUX_SEL_MSB = 2;
   localparam int POAC_OVR_EN_BIT = 7;
   localparam int POAC_REFD_MSB = 5;
   localparam int POAC_REFD_LSB = 4;
   localparam int POAC_REFC_MSB = 3;
   localparam int POAC_REFC_LSB = 2;
   localparam int POAC_SE_REF_BIT = 1;
   localparam int POAC_PLL_EN_BIT = 0;
   localparam int POAC_TRIM_MSB = 6;
   // ****************************************
   // Encodings
   // ****************************************
   localparam logic [2:0] POAC_SEL_16UI = 3'h0;
   localparam logic [2:0] POAC_SEL_32UI = 3'h1;
   localparam logic [2:0] POAC_SEL_64UI = 3'h2;
   localparam logic [2:0] POAC_SEL_TSTAMP = 3'h3;
   localparam logic [3:0] POAC_DIV_16 = 4'hF;
   localparam logic [4:0] POAC_DIV_32 = 5'h1F;
   localparam logic [5:0] POAC_DIV_64 = 6'h3F;
   localparam int POAC_CNT_W = 6;
   localparam int POAC_REFDIV_W = 3;
   typedef enum logic [1:0] {
      POAC_REF_OFF = 2'b00,
      POAC_REF_DIV1 = 2'b01,
      POAC_REF_DIV2 = 2'b10,
      POAC_REF_DIV4 = 2'b11
   } poac_ref_mode_t;
   // ****************************************
   // Carrier types
   // ****************************************
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } poac_reg_req_t;
   typedef struct packed {
      logic pll_enable;
      logic single_ended_ref;
      poac_ref_mode_t ref_c;
      poac_ref_mode_t ref_d;
   } poac_pll_cfg_t;
endpackage : poac_pkg

// >>> rtl/poac_ref_div.sv
// Divided reference clock generator for one reference output.
`timescale 1ns/1ps
module poac_ref_div (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire poac_pkg::poac_ref_mode_t i_mode,
   output logic o_clk
);
   import poac_pkg::*;
   logic [POAC_REFDIV_W-1:0] cnt_reg;
   logic [POAC_REFDIV_W-1:0] cnt_next;
   logic o_clk_next;
   // The reference is modelled by a flop toggling each edge, so each divide step doubles the period of that toggle.
   assign cnt_next = (i_mode == POAC_REF_OFF) ? '0 : cnt_reg + POAC_REFDIV_W'(1);
   assign o_clk_next = (i_mode == POAC_REF_OFF) ? 1'b0 :
                       (i_mode == POAC_REF_DIV1) ? ~o_clk :
                       (i_mode == POAC_REF_DIV2) ? cnt_reg[1] : cnt_reg[2];
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_reg <= '0;
         o_clk <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         o_clk <= o_clk_next;
      end
   end
endmodule : poac_ref_div

// >>> rtl/poac_top.sv
// Register file, PLL pin override and aux clock/timestamp output selection.
`timescale 1ns/1ps
module poac_top (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire poac_pkg::poac_reg_req_t i_reg_req,
   output logic [7:0] o_reg_rdata,
   input wire logic i_serializer_clk_en,
   input wire logic i_serializer_reinit,
   input wire logic i_timestamp_input,
   input wire logic i_pll_enable_pin,
   input wire logic i_single_ended_ref_pin,
   input wire logic i_clock_config_pin0,
   input wire logic i_clock_config_pin1,
   input wire logic i_cal_trim_load,
   input wire logic [6:0] i_cal_trim_value,
   output poac_pkg::poac_pll_cfg_t o_pll_cfg,
   output logic [6:0] o_oscillator_trim,
   output logic o_aux_output,
   output logic o_aux_divider_enable,
   output logic o_reference_output_c,
   output logic o_reference_output_d
);
   import poac_pkg::*;
   // ****************************************
   // Registers
   // ****************************************
   logic [7:0] aux_ctrl_reg;
   logic [7:0] ovr_ctrl_reg;
   logic [7:0] trim_reg;
   logic [7:0] trim_next;
   logic [7:0] rdata_next;
   logic [POAC_CNT_W-1:0] div_cnt_reg;
   logic [POAC_CNT_W-1:0] div_cnt_next;
   logic aux_out_next;
   logic tstamp_reg;
   wire wr_aux = i_reg_req.wr && (i_reg_req.addr == POAC_AUX_CTRL_ADDR);
   wire wr_ovr = i_reg_req.wr && (i_reg_req.addr == POAC_OVR_CTRL_ADDR);
   wire wr_trim = i_reg_req.wr && (i_reg_req.addr == POAC_TRIM_ADDR);
   assign rdata_next = (i_reg_req.addr == POAC_AUX_CTRL_ADDR) ? aux_ctrl_reg :
                       (i_reg_req.addr == POAC_OVR_CTRL_ADDR) ? ovr_ctrl_reg :
                       (i_reg_req.addr == POAC_TRIM_ADDR) ? trim_reg : 8'h00;
   // Software write wins over a calibration load in the same cycle; software avoids that case.
   assign trim_next = wr_trim ? i_reg_req.wdata :
                      i_cal_trim_load ? {1'b0, i_cal_trim_value} : trim_reg;
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         aux_ctrl_reg <= POAC_AUX_CTRL_RST;
         ovr_ctrl_reg <= POAC_OVR_CTRL_RST;
         trim_reg <= POAC_TRIM_RST;
         o_reg_rdata <= 8'h00;
      end else begin
         if (wr_aux) begin
            aux_ctrl_reg <= i_reg_req.wdata;
         end
         if (wr_ovr) begin
            ovr_ctrl_reg <= i_reg_req.wdata;
         end
         trim_reg <= trim_next;
         if (i_reg_req.rd) begin
            o_reg_rdata <= rdata_next;
         end
      end
   end
   assign o_oscillator_trim = trim_reg[POAC_TRIM_MSB:0];
   // ****************************************
   // PLL pin override
   // ****************************************
   wire ovr_en = ovr_ctrl_reg[POAC_OVR_EN_BIT];
   wire [1:0] pin_mode = {i_clock_config_pin1, i_clock_config_pin0};
   wire poac_ref_mode_t ref_c_mode = ovr_en ? poac_ref_mode_t'(ovr_ctrl_reg[POAC_REFC_MSB:POAC_REFC_LSB]) :
                                     poac_ref_mode_t'(pin_mode);
   wire poac_ref_mode_t ref_d_req = ovr_en ? poac_ref_mode_t'(ovr_ctrl_reg[POAC_REFD_MSB:POAC_REFD_LSB]) :
                                    poac_ref_mode_t'(pin_mode);
   // Output D is forced off whenever output C is off.
   wire poac_ref_mode_t ref_d_mode = (ref_c_mode == POAC_REF_OFF) ? POAC_REF_OFF : ref_d_req;
   assign o_pll_cfg.pll_enable = ovr_en ? ovr_ctrl_reg[POAC_PLL_EN_BIT] : i_pll_enable_pin;
   assign o_pll_cfg.single_ended_ref = ovr_en ? ovr_ctrl_reg[POAC_SE_REF_BIT] : i_single_ended_ref_pin;
   assign o_pll_cfg.ref_c = ref_c_mode;
   assign o_pll_cfg.ref_d = ref_d_mode;
   poac_ref_div u_ref_c (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_mode(ref_c_mode),
      .o_clk(o_reference_output_c)
   );
   poac_ref_div u_ref_d (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_mode(ref_d_mode),
      .o_clk(o_reference_output_d)
   );
   // ****************************************
   // Aux output
   // ****************************************
   wire aux_en = aux_ctrl_reg[POAC_AUX_EN_BIT];
   wire [2:0] aux_sel = aux_ctrl_reg[POAC_AUX_SEL_MSB:0];
   wire ser_mode = aux_sel <= POAC_SEL_64UI;
   // The divider counts serializer word strobes; reinit restarts it, which glitches the aux clock.
   wire div_run = aux_en && ser_mode && !i_serializer_reinit;
   wire [POAC_CNT_W-1:0] div_top = (aux_sel == POAC_SEL_16UI) ? {2'b00, POAC_DIV_16} :
                                   (aux_sel == POAC_SEL_32UI) ? {1'b0, POAC_DIV_32} : POAC_DIV_64;
   assign div_cnt_next = !div_run ? '0 :
                         !i_serializer_clk_en ? div_cnt_reg :
                         (div_cnt_reg == div_top) ? '0 : div_cnt_reg + 6'h01;
   wire half_bit = (aux_sel == POAC_SEL_16UI) ? div_cnt_reg[3] :
                   (aux_sel == POAC_SEL_32UI) ? div_cnt_reg[4] : div_cnt_reg[5];
   assign aux_out_next = !aux_en ? 1'b0 :
                         ser_mode ? (div_run && half_bit) :
                         (aux_sel == POAC_SEL_TSTAMP) ? tstamp_reg : 1'b0;
   assign o_aux_divider_enable = aux_en;
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         div_cnt_reg <= '0;
         tstamp_reg <= 1'b0;
         o_aux_output <= 1'b0;
      end else begin
         div_cnt_reg <= div_cnt_next;
         tstamp_reg <= i_timestamp_input;
         o_aux_output <= aux_out_next;
      end
   end
   // ****************************************
   // Assertions
   // ****************************************
   a_aux_off_static: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      !aux_en |=> !o_aux_output)
      else $error("aux output toggles while disabled");
   a_aux_enable_out: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      o_aux_divider_enable == aux_ctrl_reg[7])
      else $error("aux divider enable mismatch");
   sequence s_tstamp_mode;
      aux_en && aux_sel == POAC_SEL_TSTAMP;
   endsequence
   a_tstamp_follow: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      s_tstamp_mode ##1 s_tstamp_mode |-> o_aux_output == $past(i_timestamp_input, 2))
      else $error("timestamp not resampled onto aux output");
   a_reserved_sel_low: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      aux_sel > POAC_SEL_TSTAMP |=> !o_aux_output)
      else $error("reserved aux select drives output");
   a_reinit_stops: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      i_serializer_reinit |=> div_cnt_reg == 6'h00)
      else $error("divider not restarted by serializer reinit");
   a_pin_mode: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      !ovr_en |-> o_pll_cfg.pll_enable == i_pll_enable_pin && o_pll_cfg.ref_c == pin_mode)
      else $error("pin mode not followed");
   a_ovr_pll_en: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      ovr_en |-> o_pll_cfg.pll_enable == ovr_ctrl_reg[0] && o_pll_cfg.single_ended_ref == ovr_ctrl_reg[1])
      else $error("override values not applied");
   a_ovr_ref_c: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      ovr_en |-> o_pll_cfg.ref_c == ovr_ctrl_reg[3:2])
      else $error("output C select not applied");
   a_d_needs_c: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      o_pll_cfg.ref_c == POAC_REF_OFF |=> !o_reference_output_d)
      else $error("output D clocks without output C");
   a_ovr_ref_d: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      ovr_en && o_pll_cfg.ref_c != POAC_REF_OFF |-> o_pll_cfg.ref_d == ovr_ctrl_reg[5:4])
      else $error("output D select not applied");
   a_trim_write: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      wr_trim |=> trim_reg == $past(i_reg_req.wdata))
      else $error("trim write lost");
   a_cal_load: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      i_cal_trim_load && !wr_trim |=> o_oscillator_trim == $past(i_cal_trim_value))
      else $error("calibration trim load lost");
endmodule : poac_top

// >>> tb/tb_poac_top.sv
// Self-checking testbench for the PLL override and aux clock output block.
`timescale 1ns/1ps
module tb_poac_top;
   import poac_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_nrst = 1'b0;
   poac_reg_req_t req = '0;
   logic tstamp = 1'b0;
   logic reinit = 1'b0;
   logic pll_pin = 1'b1;
   logic se_pin = 1'b0;
   logic cfg0 = 1'b0;
   logic cfg1 = 1'b1;
   logic cal_load = 1'b0;
   logic [6:0] cal_val = 7'h00;
   logic [7:0] rdata;
   poac_pll_cfg_t cfg;
   logic [6:0] trim;
   logic aux, aux_en, ref_c, ref_d;
   wire [2:0] mon = {aux, ref_d, ref_c};
   int mismatches = 0;
   int check_count = 0;
   logic [7:0] v;
   int r;

   poac_top u_poac_top (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_reg_req(req), .o_reg_rdata(rdata),
      .i_serializer_clk_en(1'b1), .i_serializer_reinit(reinit), .i_timestamp_input(tstamp),
      .i_pll_enable_pin(pll_pin), .i_single_ended_ref_pin(se_pin), .i_clock_config_pin0(cfg0),
      .i_clock_config_pin1(cfg1), .i_cal_trim_load(cal_load), .i_cal_trim_value(cal_val), .o_pll_cfg(cfg),
      .o_oscillator_trim(trim), .o_aux_output(aux), .o_aux_divider_enable(aux_en),
      .o_reference_output_c(ref_c), .o_reference_output_d(ref_d));

   // ****************************************
   // Shared tasks
   // ****************************************
   task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_core_clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge i_core_clk);
      req <= '0;
   endtask : wr

   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_core_clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge i_core_clk);
      req <= '0;
      @(posedge i_core_clk);
      #1 d = rdata;
   endtask : rd

   // Counts rising edges of one monitored output over n cycles.
   task rise(input int w, input int n, output int cnt);
      logic p;
      cnt = 0;
      @(posedge i_core_clk);
      #1 p = mon[w];
      repeat (n) begin
         @(posedge i_core_clk);
         #1 if (mon[w] === 1'b1 && p === 1'b0) cnt++;
         p = mon[w];
      end
   endtask : rise

   // ****************************************
   // Scenarios
   // ****************************************
   task t_regs;
      for (int i = 0; i < 4; i++) begin
         rd(8'h57 + 8'(i), v);
         chk("reset_read", 8'h00, v);
      end
      chk("pin_cfg", 8'h2A, {2'h0, cfg});
      wr(8'h59, 8'h55);
      rd(8'h59, v);
      chk("trim_read", 8'h55, v);
      chk("trim_out", 8'h55, {1'b0, trim});
      wr(8'h5A, 8'hFF);
      rd(8'h5A, v);
      chk("unmapped", 8'h00, v);
      @(posedge i_core_clk);
      cal_load <= 1'b1;
      cal_val <= 7'h2A;
      @(posedge i_core_clk);
      cal_load <= 1'b0;
      rd(8'h59, v);
      chk("cal_load", 8'h2A, v);
      @(posedge i_core_clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: 8'h59, wdata: 8'h11};
      cal_load <= 1'b1;
      cal_val <= 7'h66;
      @(posedge i_core_clk);
      req <= '0;
      cal_load <= 1'b0;
      rd(8'h59, v);
      chk("trim_wins", 8'h11, v);
   endtask : t_regs

   task t_ovr;
      wr(8'h58, 8'h1F);
      rd(8'h58, v);
      chk("ovr_read", 8'h1F, v);
      chk("fields_ignored", 8'h2A, {2'h0, cfg});
      @(posedge i_core_clk);
      pll_pin <= 1'b0;
      se_pin <= 1'b1;
      cfg0 <= 1'b1;
      @(posedge i_core_clk);
      #1 chk("pins_follow", 8'h1F, {2'h0, cfg});
      rise(0, 16, r);
      chk("pin_ref_c", 8'd2, 8'(r));
      wr(8'h58, 8'h9E);
      #1 chk("ovr_fields", 8'h1D, {2'h0, cfg});
      wr(8'h58, 8'h81);
      #1 chk("ovr_pll_en", 8'h20, {2'h0, cfg});
      for (int m = 0; m < 4; m++) begin
         wr(8'h58, 8'h90 | 8'(m << 2));
         repeat (3) @(posedge i_core_clk);
         rise(0, 16, r);
         chk("ref_c_rate", (m == 0) ? 8'd0 : 8'(16 >> m), 8'(r));
         rise(1, 16, r);
         chk("ref_d_gate", (m == 0) ? 8'd0 : 8'd8, 8'(r));
         wr(8'h58, 8'h84 | 8'(m << 4));
         repeat (3) @(posedge i_core_clk);
         rise(1, 16, r);
         chk("ref_d_rate", (m == 0) ? 8'd0 : 8'(16 >> m), 8'(r));
      end
   endtask : t_ovr

   task t_aux;
      rise(2, 64, r);
      chk("aux_idle", 8'd0, 8'(r));
      chk("div_off", 8'h00, {7'h0, aux_en});
      for (int s = 0; s < 3; s++) begin
         wr(8'h57, 8'(s));
         wr(8'h57, 8'h80 | 8'(s));
         repeat (4) @(posedge i_core_clk);
         chk("div_on", 8'h01, {7'h0, aux_en});
         rise(2, 128, r);
         chk("aux_rate", 8'(128 >> (4 + s)), 8'(r));
         @(posedge i_core_clk);
         reinit <= 1'b1;
         repeat (3) @(posedge i_core_clk);
         #1 chk("aux_reinit", 8'h00, {7'h0, aux});
         @(posedge i_core_clk);
         reinit <= 1'b0;
         wr(8'h57, 8'h00);
      end
      wr(8'h57, 8'h03);
      wr(8'h57, 8'h83);
      for (int k = 0; k < 2; k++) begin
         @(posedge i_core_clk);
         tstamp <= ~tstamp;
         repeat (3) @(posedge i_core_clk);
         #1 chk("aux_tstamp", {7'h0, tstamp}, {7'h0, aux});
      end
      wr(8'h57, 8'h00);
      wr(8'h57, 8'h04);
      wr(8'h57, 8'h84);
      rise(2, 64, r);
      chk("aux_reserved", 8'd0, 8'(r));
   endtask : t_aux

   // ****************************************
   // Run control
   // ****************************************
   task stop_test;
      if (mismatches == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test

   initial begin
      forever #5 i_core_clk = ~i_core_clk;
   end

   initial begin
      repeat (20000) @(posedge i_core_clk);
      mismatches++;
      stop_test();
   end

   initial begin
      repeat (8) @(posedge i_core_clk);
      i_nrst <= 1'b1;
      t_regs();
      t_ovr();
      t_aux();
      stop_test();
   end
endmodule : tb_poac_top
